// *** rx_cfg_consts.svh ***
/*
  Offsets, field positions, reset values and timing counts of the receiver
  gain and mask timer block. Included by its bare name.
*/
`ifndef RX_CFG_CONSTS_SVH
`define RX_CFG_CONSTS_SVH
`define ADDR_FIRST_GAIN 8'h0C
`define ADDR_LATER_GAIN 8'h0D
`define ADDR_MASK 8'h0E
`define RST_FIRST_GAIN 8'hD8
`define RST_LATER_GAIN 8'h00
`define RST_MASK 8'h08
`define FG_AM_HI 7
`define FG_AM_LO 5
`define FG_PM_HI 4
`define FG_PM_LO 2
`define FG_CLIP 1
`define FG_PEER 0
`define LG_AM_HI 7
`define LG_AM_LO 4
`define LG_PM_HI 3
`define LG_PM_LO 0
`define GAIN1_BOOST 3'h7
`define GAIN2_MAX_USED 4'hA
`define GAIN2_WIN_ONLY 4'h4
`define PEER_STAGE_DB 4'h6
`define MASK_MIN_STEPS 8'h04
`define STEP_FC_NORMAL 10'h03F
`define STEP_FC_PEER 10'h1FF
`define SQUELCH_DELAY_FC 10'h100
`endif

// *** rx_cfg_pkg.sv ***
/*
  Types shared by the receiver configuration files.
  Assumes the constants header is included by users.
*/
package rx_cfg_pkg;
  typedef enum logic [1:0] {
    MASK_IDLE,
    MASK_RUN
  } mask_state_t;
  typedef enum logic [1:0] {
    STEP_NORMAL,
    STEP_PEER,
    STEP_HALF_FDT
  } step_mode_t;
endpackage : rx_cfg_pkg

// *** rx_gain_mask.sv ***
/*
  Receiver gain configuration registers and the mask receive timer.
  Assumes clk is the carrier clock fc and register writes arrive from the
  host interface already synchronous to it. End of transmission is a pulse.
*/
`timescale 1ns/1ps
`include "rx_cfg_consts.svh"
// Overview of operation
// (RQ1) AM code: 0 full, 1-6 cut, 7 boost
// (RQ2) PM first gain coded like AM
// (RQ3) Clip bit limits first two stages
// (RQ4) Peer override forces -6 dB, widest window
// (RQ5) Host restarts receiver after clearing override
// (RQ6) Defaults at reset and set-default command
// (RQ7) AM later gain 0-A, window then stage
// (RQ8) PM later gain coded like AM
// (RQ9) Later gain applied only on gain reset command
// (RQ10) Mask blanks receiver after end of transmit
// (RQ11) Mask time is value times 64/fc
// (RQ12) Values 0 to 4 give four steps
// (RQ13) Bit rate detection makes steps 512/fc
// (RQ14) Half-FDT steps for 106 kbit/s A
// (RQ15) Auto squelch from 256/fc until mask end
// (RQ16) Each end of transmit restarts mask timer
module rx_gain_mask (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Commands
  input wire logic cmd_set_default,
  input wire logic cmd_reset_rx_gain,
  // Receiver context
  input wire logic tx_end,
  input wire logic bitrate_detect_mode,
  input wire logic iso_a_106_mode,
  input wire logic [9:0] half_fdt_fc,
  input wire logic auto_squelch_en,
  input wire logic rx_data_raw,
  // Analog controls
  output logic [2:0] am_first_stage_gain_code,
  output logic [2:0] pm_first_stage_gain_code,
  output logic [2:0] am_first_stage_cut_steps,
  output logic [2:0] pm_first_stage_cut_steps,
  output logic am_first_stage_boost,
  output logic pm_first_stage_boost,
  output logic clip_enable,
  output logic peer_mode_gain_override,
  output logic [3:0] am_later_stage_gain_code,
  output logic [3:0] pm_later_stage_gain_code,
  output logic [2:0] am_window_steps,
  output logic [2:0] pm_window_steps,
  output logic [3:0] am_stage_cut_steps,
  output logic [3:0] pm_stage_cut_steps,
  output logic [3:0] stage_cut_db_override,
  output logic max_window,
  // Mask and squelch
  output logic rx_masked,
  output logic rx_data_gated,
  output logic squelch_active
);
  logic [7:0] first_q;
  logic [7:0] later_q;
  logic [7:0] mask_q;
  logic [7:0] applied_q;
  logic [7:0] rdata_q;
  logic [7:0] left_q;
  logic [9:0] sq_cnt_q;
  logic sq_q;
  logic [9:0] terminal;
  logic step;
  logic [7:0] load_steps;
  rx_cfg_pkg::mask_state_t state_q;
  rx_cfg_pkg::step_mode_t mode;
  logic [2:0] am_cut1_q;
  logic [2:0] pm_cut1_q;
  logic am_boost_q;
  logic pm_boost_q;
  logic [2:0] am_win_q;
  logic [2:0] pm_win_q;
  logic [3:0] am_cut2_q;
  logic [3:0] pm_cut2_q;
  logic raw_meta_q;
  logic raw_sync_q;
  logic gated_q;

  // Stage-one code: number of 2.5 dB cuts, zero when full or boosted
  function automatic logic [2:0] cut1(input logic [2:0] code);
    cut1 = (code == `GAIN1_BOOST) ? 3'h0 : code;
  endfunction : cut1

  // Stage two/three: 1-4 widen window, 5-A also cut stage gain
  function automatic logic [2:0] win2(input logic [3:0] code);
    if (code > `GAIN2_MAX_USED) begin
      win2 = 3'h4;
    end else if (code > `GAIN2_WIN_ONLY) begin
      win2 = 3'h4;
    end else begin
      win2 = code[2:0];
    end
  endfunction : win2

  function automatic logic [3:0] cut2(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `GAIN2_MAX_USED) ? `GAIN2_MAX_USED : code;
    cut2 = (c > `GAIN2_WIN_ONLY) ? c - `GAIN2_WIN_ONLY : 4'h0;
  endfunction : cut2

  // Field extraction from a register image
  function automatic logic [2:0] am1_field(input logic [7:0] r);
    am1_field = r[`FG_AM_HI:`FG_AM_LO];
  endfunction : am1_field

  function automatic logic [2:0] pm1_field(input logic [7:0] r);
    pm1_field = r[`FG_PM_HI:`FG_PM_LO];
  endfunction : pm1_field

  function automatic logic [3:0] am2_field(input logic [7:0] r);
    am2_field = r[`LG_AM_HI:`LG_AM_LO];
  endfunction : am2_field

  function automatic logic [3:0] pm2_field(input logic [7:0] r);
    pm2_field = r[`LG_PM_HI:`LG_PM_LO];
  endfunction : pm2_field

  // Register file with defaults
  always_ff @(posedge clk) begin
    if (rst || cmd_set_default) begin // [RQ6]
      first_q <= `RST_FIRST_GAIN;
      later_q <= `RST_LATER_GAIN;
      mask_q <= `RST_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_FIRST_GAIN: first_q <= reg_wdata;
        `ADDR_LATER_GAIN: later_q <= reg_wdata;
        `ADDR_MASK: mask_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Later-stage value reaches AGC/squelch/RSSI only on command
  always_ff @(posedge clk) begin
    if (rst || cmd_set_default) begin
      applied_q <= `RST_LATER_GAIN;
    end else if (cmd_reset_rx_gain) begin // [RQ9]
      applied_q <= later_q;
    end
  end

  // Decoded first-stage controls load in the same edge as the register
  always_ff @(posedge clk) begin
    if (rst || cmd_set_default) begin
      am_cut1_q <= cut1(am1_field(`RST_FIRST_GAIN));
      pm_cut1_q <= cut1(pm1_field(`RST_FIRST_GAIN));
      am_boost_q <= am1_field(`RST_FIRST_GAIN) == `GAIN1_BOOST;
      pm_boost_q <= pm1_field(`RST_FIRST_GAIN) == `GAIN1_BOOST;
    end else if (reg_wr && reg_addr == `ADDR_FIRST_GAIN) begin
      am_cut1_q <= cut1(am1_field(reg_wdata)); // [RQ1]
      pm_cut1_q <= cut1(pm1_field(reg_wdata)); // [RQ2]
      am_boost_q <= am1_field(reg_wdata) == `GAIN1_BOOST; // [RQ1]
      pm_boost_q <= pm1_field(reg_wdata) == `GAIN1_BOOST; // [RQ2]
    end
  end

  // Decoded later-stage controls load with the applied copy
  always_ff @(posedge clk) begin
    if (rst || cmd_set_default) begin
      am_win_q <= win2(am2_field(`RST_LATER_GAIN));
      pm_win_q <= win2(pm2_field(`RST_LATER_GAIN));
      am_cut2_q <= cut2(am2_field(`RST_LATER_GAIN));
      pm_cut2_q <= cut2(pm2_field(`RST_LATER_GAIN));
    end else if (cmd_reset_rx_gain) begin // [RQ9]
      am_win_q <= win2(am2_field(later_q)); // [RQ7]
      pm_win_q <= win2(pm2_field(later_q)); // [RQ8]
      am_cut2_q <= cut2(am2_field(later_q)); // [RQ7]
      pm_cut2_q <= cut2(pm2_field(later_q)); // [RQ8]
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_FIRST_GAIN: rdata_q <= first_q;
        `ADDR_LATER_GAIN: rdata_q <= later_q;
        `ADDR_MASK: rdata_q <= mask_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // First stage decode
  assign am_first_stage_gain_code = am1_field(first_q);
  assign pm_first_stage_gain_code = pm1_field(first_q);
  assign am_first_stage_cut_steps = am_cut1_q; // [RQ1]
  assign pm_first_stage_cut_steps = pm_cut1_q; // [RQ2]
  assign am_first_stage_boost = am_boost_q; // [RQ1]
  assign pm_first_stage_boost = pm_boost_q; // [RQ2]
  assign clip_enable = first_q[`FG_CLIP]; // [RQ3]
  // Clearing this needs a receiver restart by the host [RQ5]
  assign peer_mode_gain_override = first_q[`FG_PEER];
  assign stage_cut_db_override =
    peer_mode_gain_override ? `PEER_STAGE_DB : 4'h0; // [RQ4]
  assign max_window = peer_mode_gain_override; // [RQ4]

  // Later stage decode, from the applied copy
  assign am_later_stage_gain_code = am2_field(applied_q);
  assign pm_later_stage_gain_code = pm2_field(applied_q);
  assign am_window_steps = am_win_q; // [RQ7]
  assign pm_window_steps = pm_win_q; // [RQ8]
  assign am_stage_cut_steps = am_cut2_q; // [RQ7]
  assign pm_stage_cut_steps = pm_cut2_q; // [RQ8]

  // Step length select; half-FDT length is supplied by framing logic
  always_comb begin
    if (bitrate_detect_mode) begin
      mode = rx_cfg_pkg::STEP_PEER;
    end else if (iso_a_106_mode) begin
      mode = rx_cfg_pkg::STEP_HALF_FDT;
    end else begin
      mode = rx_cfg_pkg::STEP_NORMAL;
    end
    case (mode)
      rx_cfg_pkg::STEP_PEER: terminal = `STEP_FC_PEER; // [RQ13]
      rx_cfg_pkg::STEP_HALF_FDT: terminal = half_fdt_fc; // [RQ14]
      default: terminal = `STEP_FC_NORMAL; // [RQ11]
    endcase
  end

  step_prescaler u_step (
    .clk(clk),
    .rst(rst),
    .restart(tx_end),
    .terminal(terminal),
    .step(step)
  );

  // Short values clamp to the minimum to ride out transmit transients
  assign load_steps =
    (mask_q <= `MASK_MIN_STEPS) ? `MASK_MIN_STEPS : mask_q; // [RQ12]

  // Mask timer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rx_cfg_pkg::MASK_IDLE;
      left_q <= 8'h00;
    end else if (tx_end) begin // [RQ16]
      state_q <= rx_cfg_pkg::MASK_RUN;
      left_q <= load_steps; // [RQ11]
    end else begin
      case (state_q)
        rx_cfg_pkg::MASK_RUN: begin
          if (step) begin
            if (left_q == 8'h01) begin
              state_q <= rx_cfg_pkg::MASK_IDLE; // [RQ16]
              left_q <= 8'h00;
            end else begin
              left_q <= left_q - 8'h01;
            end
          end
        end
        default: state_q <= rx_cfg_pkg::MASK_IDLE;
      endcase
    end
  end

  assign rx_masked = state_q == rx_cfg_pkg::MASK_RUN; // [RQ10]

  // Receiver data is not timed to fc, so two flops before any use
  always_ff @(posedge clk) begin
    raw_meta_q <= rx_data_raw;
    raw_sync_q <= raw_meta_q;
  end

  // tx_end closes the gate on the same edge that the mask state rises
  always_ff @(posedge clk) begin
    gated_q <= raw_sync_q && !rx_masked && !tx_end; // [RQ10]
  end
  assign rx_data_gated = gated_q; // [RQ10]

  // Automatic squelch window
  always_ff @(posedge clk) begin
    if (rst || tx_end) begin
      sq_cnt_q <= 10'h000;
    end else if (rx_masked && sq_cnt_q != `SQUELCH_DELAY_FC) begin
      sq_cnt_q <= sq_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || tx_end || !rx_masked || !auto_squelch_en) begin
      sq_q <= 1'b0;
    end else if (sq_cnt_q == `SQUELCH_DELAY_FC - 10'h001) begin
      sq_q <= 1'b1; // [RQ15]
    end
  end
  assign squelch_active = sq_q && rx_masked; // [RQ15]
endmodule : rx_gain_mask

// *** rx_gain_mask_props.sv ***
/* Port checker for rx_gain_mask.
   Assumes clk is fc; bound to every instance. */
`timescale 1ns/1ps
module rx_gain_mask_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs watched
  input wire logic tx_end,
  input wire logic iso_a_106_mode,
  input wire logic rx_data_raw,
  input wire logic cmd_set_default,
  // Outputs watched
  input wire logic [2:0] am_first_stage_gain_code,
  input wire logic am_first_stage_boost,
  input wire logic clip_enable,
  input wire logic peer_mode_gain_override,
  input wire logic [3:0] stage_cut_db_override,
  input wire logic max_window,
  input wire logic rx_masked,
  input wire logic rx_data_gated,
  input wire logic squelch_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Saturates so long bit rate detection masks cannot wrap
  logic [13:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst || tx_end) cnt_q <= 14'h0000;
    else if (rx_masked && !(&cnt_q)) cnt_q <= cnt_q + 14'h0001;
  end
  sequence s_mask_on;
    tx_end ##1 rx_masked;
  endsequence
  property p_tx; tx_end |-> s_mask_on; endproperty
  property p_rise; $rose(rx_masked) |-> $past(tx_end); endproperty
  property p_min;
    $fell(rx_masked) && !iso_a_106_mode |-> cnt_q >= 14'h00FF;
  endproperty
  property p_gate;
    rx_data_gated == ($past(rx_data_raw, 3) && !$past(rx_masked)
      && !$past(tx_end));
  endproperty
  property p_sq; squelch_active |-> rx_masked; endproperty
  property p_peer;
    stage_cut_db_override == (peer_mode_gain_override ? 4'h6 : 4'h0)
      && max_window == peer_mode_gain_override;
  endproperty
  property p_boost;
    am_first_stage_boost == (am_first_stage_gain_code == 3'h7);
  endproperty
  property p_def;
    cmd_set_default |-> ##[1:2] am_first_stage_gain_code == 3'h6
      && !clip_enable && !peer_mode_gain_override;
  endproperty
  a_tx: assert property (p_tx) else $error("mask not raised");
  a_rise: assert property (p_rise) else $error("mask w/o tx end");
  a_min: assert property (p_min) else $error("mask too short");
  a_gate: assert property (p_gate) else $error("gating wrong");
  a_sq: assert property (p_sq) else $error("squelch outside mask");
  a_peer: assert property (p_peer) else $error("override wrong");
  a_boost: assert property (p_boost) else $error("boost wrong");
  a_def: assert property (p_def) else $error("defaults wrong");
endmodule : rx_gain_mask_props
bind rx_gain_mask rx_gain_mask_props u_props (
  .clk(clk),
  .rst(rst),
  .tx_end(tx_end),
  .iso_a_106_mode(iso_a_106_mode),
  .rx_data_raw(rx_data_raw),
  .cmd_set_default(cmd_set_default),
  .am_first_stage_gain_code(am_first_stage_gain_code),
  .am_first_stage_boost(am_first_stage_boost),
  .clip_enable(clip_enable),
  .peer_mode_gain_override(peer_mode_gain_override),
  .stage_cut_db_override(stage_cut_db_override),
  .max_window(max_window),
  .rx_masked(rx_masked),
  .rx_data_gated(rx_data_gated),
  .squelch_active(squelch_active)
);

// *** rx_gain_mask_tb.sv ***
/* Bench for rx_gain_mask.
   Inputs change on falling edges of a 200 MHz fc. */
`timescale 1ns/1ps
module rx_gain_mask_tb;
  logic clk, rst, reg_wr, reg_rd, cmd_set_default, cmd_reset_rx_gain;
  logic tx_end, bitrate_detect_mode, iso_a_106_mode, auto_squelch_en;
  logic rx_data_raw, am_first_stage_boost, pm_first_stage_boost;
  logic clip_enable, peer_mode_gain_override, max_window;
  logic rx_masked, rx_data_gated, squelch_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [9:0] half_fdt_fc;
  logic [2:0] am_first_stage_gain_code, pm_first_stage_gain_code;
  logic [2:0] am_first_stage_cut_steps, pm_first_stage_cut_steps;
  logic [2:0] am_window_steps, pm_window_steps;
  logic [3:0] am_later_stage_gain_code, pm_later_stage_gain_code;
  logic [3:0] am_stage_cut_steps, pm_stage_cut_steps;
  logic [3:0] stage_cut_db_override;
  int err_count = 0;
  int total_checks = 0;
  rx_gain_mask dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cmd_set_default(cmd_set_default),
    .cmd_reset_rx_gain(cmd_reset_rx_gain), .tx_end(tx_end),
    .bitrate_detect_mode(bitrate_detect_mode),
    .iso_a_106_mode(iso_a_106_mode), .half_fdt_fc(half_fdt_fc),
    .auto_squelch_en(auto_squelch_en), .rx_data_raw(rx_data_raw),
    .am_first_stage_gain_code(am_first_stage_gain_code),
    .pm_first_stage_gain_code(pm_first_stage_gain_code),
    .am_first_stage_cut_steps(am_first_stage_cut_steps),
    .pm_first_stage_cut_steps(pm_first_stage_cut_steps),
    .am_first_stage_boost(am_first_stage_boost),
    .pm_first_stage_boost(pm_first_stage_boost),
    .clip_enable(clip_enable),
    .peer_mode_gain_override(peer_mode_gain_override),
    .am_later_stage_gain_code(am_later_stage_gain_code),
    .pm_later_stage_gain_code(pm_later_stage_gain_code),
    .am_window_steps(am_window_steps), .pm_window_steps(pm_window_steps),
    .am_stage_cut_steps(am_stage_cut_steps),
    .pm_stage_cut_steps(pm_stage_cut_steps),
    .stage_cut_db_override(stage_cut_db_override),
    .max_window(max_window), .rx_masked(rx_masked),
    .rx_data_gated(rx_data_gated), .squelch_active(squelch_active)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(string n, logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic wr(logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    pulse(reg_wr);
    cyc(2);
  endtask : wr
  task automatic rd(logic [7:0] a, e);
    reg_addr = a;
    pulse(reg_rd);
    cyc(1);
    chk("rdata", reg_rdata, e);
  endtask : rd
  // Later stage expectation: window caps at 4, stage cut beyond it
  function automatic logic [6:0] gexp(logic [3:0] c);
    return {(c > 4'h4) ? 3'h4 : c[2:0], (c > 4'h4) ? c - 4'h4 : 4'h0};
  endfunction : gexp
  task automatic t_regs();
    rd(8'h0C, 8'hD8);
    rd(8'h0D, 8'h00);
    rd(8'h0F, 8'h00);
    wr(8'h0E, 8'h33);
    rd(8'h0E, 8'h33);
    pulse(cmd_set_default);
    rd(8'h0E, 8'h08);
    $display("regs end");
  endtask : t_regs
  task automatic t_first();
    for (int c = 0; c < 8; c++) begin
      wr(8'h0C, {c[2:0], c[2:0], 2'h3});
      chk("am1", am_first_stage_gain_code, c[2:0]);
      chk("pm1", pm_first_stage_gain_code, c[2:0]);
      chk("cut1", pm_first_stage_cut_steps, c == 7 ? 3'h0 : c[2:0]);
      chk("cut1a", am_first_stage_cut_steps, c == 7 ? 3'h0 : c[2:0]);
      chk("boost", {am_first_stage_boost, pm_first_stage_boost},
        c == 7 ? 2'h3 : 2'h0);
      chk("peer on", {peer_mode_gain_override, max_window,
        stage_cut_db_override}, 6'h36);
      chk("clip", clip_enable, 1'b1);
    end
    wr(8'h0C, 8'h00);
    pulse(cmd_reset_rx_gain);
    chk("peer", {max_window, stage_cut_db_override}, 5'h00);
    $display("first end");
  endtask : t_first
  task automatic t_later();
    for (int c = 0; c < 11; c++) begin
      wr(8'h0D, {c[3:0], 4'hA - c[3:0]});
      pulse(cmd_reset_rx_gain);
      cyc(2);
      chk("am2", {am_window_steps, am_stage_cut_steps}, gexp(c[3:0]));
      chk("pm2", {pm_window_steps, pm_stage_cut_steps},
        gexp(4'hA - c[3:0]));
    end
    wr(8'h0D, 8'h55);
    chk("held", {am_later_stage_gain_code, pm_later_stage_gain_code},
      8'hA0);
    $display("later end");
  endtask : t_later
  task automatic t_mask(logic [7:0] v, logic [2:0] m, int pre, int x);
    int n = 0;
    int s = 0;
    int g = 0;
    {auto_squelch_en, bitrate_detect_mode, iso_a_106_mode} = m;
    wr(8'h0E, v);
    if (pre > 0) begin
      pulse(tx_end);
      cyc(pre);
    end
    pulse(tx_end);
    for (int i = 0; i < 20000 && (n == 0 || rx_masked === 1'b1); i++) begin
      n += (rx_masked === 1'b1);
      s += (squelch_active === 1'b1);
      g += (rx_masked === 1'b1 && rx_data_gated !== 1'b0);
      rx_data_raw = i[0];
      cyc(1);
    end
    if (rx_masked !== 1'b0) begin
      err_count++;
      wrap_up();
    end
    rx_data_raw = 1'b1;
    cyc(4);
    chk("mask len", 16'(n), 16'(x));
    chk("squelch", 16'(s), m[2] ? 16'(x - 256) : 16'h0000);
    chk("leak", 16'(g), 16'h0000);
    chk("gated", rx_data_gated, 1'b1);
    $display("mask end");
  endtask : t_mask
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, cmd_set_default, cmd_reset_rx_gain, tx_end} = '0;
    {bitrate_detect_mode, iso_a_106_mode, auto_squelch_en} = '0;
    {reg_addr, reg_wdata} = '0;
    half_fdt_fc = 10'h009;
    rx_data_raw = 1'b1;
    cyc(3);
    rst = 1'b0;
    t_regs();
    t_first();
    t_later();
    t_mask(8'h00, 3'h0, 0, 256);
    t_mask(8'h0A, 3'h0, 0, 640);
    t_mask(8'hFF, 3'h0, 0, 16320);
    t_mask(8'h02, 3'h2, 0, 2048);
    t_mask(8'h05, 3'h1, 0, 50);
    t_mask(8'h04, 3'h0, 100, 256);
    t_mask(8'h08, 3'h4, 0, 512);
    wrap_up();
  end
endmodule : rx_gain_mask_tb

// *** step_prescaler.sv ***
/*
  Prescaler producing one pulse per mask timer step on the fc clock.
  Assumes clk is fc and restart comes from the same domain.
*/
`timescale 1ns/1ps
`include "rx_cfg_consts.svh"
module step_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic [9:0] terminal,
  // Step pulse
  output logic step
);
  logic [9:0] cnt_q;

  always_ff @(posedge clk) begin
    if (rst || restart || cnt_q >= terminal) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  assign step = !rst && !restart && cnt_q >= terminal;
endmodule : step_prescaler
